// [include/ebs_cs_if.sv]
// Purpose: Chip select decode signals between the boot loader and overlay decoder
// Assumes: One clock domain
// Notes: Active high inside; pins invert at the top
`timescale 1ns/1ps
interface ebs_cs_if;
    logic [6:0] cs_hit;
    logic emu_hit;
    logic [6:0] ovl_en;
    logic [6:0] cs_sel;
    logic ovl_sel;
    logic emu_sel;
    modport ctrl (output cs_hit, output emu_hit, output ovl_en, input cs_sel, input ovl_sel, input emu_sel);
    modport dec (input cs_hit, input emu_hit, input ovl_en, output cs_sel, output ovl_sel, output emu_sel);
endinterface

// [include/ebs_pkg.sv]
// Purpose: Shared constants and types for the external bus boot and emulation select block
// Assumes: 100 MHz ref_clk, 32-bit external data bus, 24-bit external address
// Notes: Boot word field positions follow the configuration word layout
package ebs_pkg;
    localparam int EBS_CLK_MHZ = 100;
    localparam int EBS_NUM_CS = 7;
    localparam int EBS_ADDR_W = 24;
    localparam int EBS_IDLE_CYCLES = 256;
    localparam logic [8:0] EBS_IDLE_COUNT = 9'h100;
    localparam int EBS_WAITRDC_MAX = 7;
    localparam int EBS_CMULT_MAX = 32;
    localparam logic [7:0] EBS_READ_WAIT_COUNT = 8'(EBS_WAITRDC_MAX * EBS_CMULT_MAX);
    localparam logic [EBS_ADDR_W-1:0] EBS_CFG_ADDR = 24'h000004;
    localparam logic [EBS_ADDR_W-1:0] EBS_FETCH_ADDR = 24'h000000;
    localparam logic [31:0] EBS_EMU_BASE = 32'hde000000;
    localparam logic [7:0] EBS_EMU_SEG_TOP = 8'hde;
    localparam int EBS_WIDTH_BIT = 15;
    localparam int EBS_CMULT_LSB = 12;
    localparam int EBS_BUS_CLOCK_GENERATION_LSB = 10;
    localparam int EBS_WAIT_LSB = 8;
    localparam int EBS_WINV_BIT = 7;
    localparam int EBS_ADDRC_LSB = 5;
    localparam int EBS_WAITRDC_LSB = 2;
    localparam logic [1:0] EBS_PORTW_16 = 2'h1;
    localparam logic [1:0] EBS_PORTW_32 = 2'h2;
    localparam logic [15:0] EBS_BUSCON_RESET = 16'h0000;
    localparam logic [15:0] EBS_BUSAP_RESET = 16'h0000;
    // Emulation defaults: arbitrary neutral presets
    localparam logic [15:0] EBS_EMU_AS_RESET = 16'hde01;
    localparam logic [15:0] EBS_EMU_BC_RESET = 16'h0201;
    localparam logic [15:0] EBS_EMU_BAP_RESET = 16'h001c;
    typedef enum logic [5:0] {
        EBS_RESET = 6'h01,
        EBS_IDLE = 6'h02,
        EBS_READ = 6'h04,
        EBS_APPLY = 6'h08,
        EBS_RUN = 6'h10,
        EBS_OFF = 6'h20
    } ebs_state_type;
endpackage

// [logic/ebs_boot_ctrl.sv]
// Purpose: Boot configuration loader and emulation select for the external_bus_unit
// Assumes: Boot memory on boot_chip_select, demultiplexed bus, 16 or 32 bit ROM
// Notes: Local requests are retried during the configuration read
`timescale 1ns/1ps
module ebs_boot_ctrl
    import ebs_pkg::*;
(
    input wire logic ref_clk, // Bus unit clock
    input wire logic rst_b, // Async reset, active low
    input wire logic ext_boot, // External boot strap
    input wire logic emu_boot, // Emulation boot strap
    input wire logic master_pin, // Master/slave config pin
    input wire logic wait_b, // External wait pin
    input wire logic hold_acknowledge_b, // Hold acknowledge pin
    input wire logic [31:0] rd_data, // External read data
    input wire logic lmb_req, // Local bus request
    input wire logic [31:0] lmb_addr, // Local bus address
    input wire logic [6:0] overlay_enable_control, // Overlay enables per select
    input wire logic [6:0] cs_hit, // Region hit per select
    output logic [EBS_ADDR_W-1:0] ext_addr, // External address
    output logic rd_b, // Read strobe, active low
    output logic boot_chip_select_b, // Chip select zero, active low
    output logic [6:0] cs_b, // Regular selects, active low
    output logic overlay_chip_select_b, // Overlay select, active low
    output logic emulation_chip_select_b, // Emulation select, active low
    output logic lmb_retry, // Retry answer
    output logic lmb_error, // Refusal answer
    output logic bus_owner, // Unit owns external bus
    output logic ext_master, // Master mode sampled
    output logic arb_enable, // Arbitration on
    output logic unit_enable, // Unit enabled
    output logic [31:0] cpu_pc, // Start program counter
    output logic pc_load, // Load PC strobe
    output logic fetch_start, // First code fetch
    output logic [1:0] port_width, // Chip select zero width
    output logic [15:0] chip_select_bus_control, // Select zero control
    output logic [15:0] chip_select_access_parameters, // Select zero timing
    output logic [15:0] emulation_address_select, // Emulation region
    output logic [15:0] emulation_bus_control, // Emulation control
    output logic [15:0] emulation_access_parameters, // Emulation timing
    output logic boot_done // Configuration finished
);
    ebs_state_type state, next_state;
    logic [8:0] idle_cnt;
    logic [7:0] wait_cnt;
    logic [2:0] ext_boot_s, emu_boot_s, master_s, hold_acknowledge_s, wait_s;
    logic [31:0] cfg_word;
    logic boot_mode, emu_mode, strap_taken;
    logic [1:0] strap_cnt;
    ebs_cs_if cs ();

    // Straps and pins cross three stages before use
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_boot_s <= 3'h0;
            emu_boot_s <= 3'h0;
            master_s <= 3'h0;
            hold_acknowledge_s <= 3'h7;
            wait_s <= 3'h7;
        end else begin
            ext_boot_s <= {ext_boot_s[1:0], ext_boot};
            emu_boot_s <= {emu_boot_s[1:0], emu_boot};
            master_s <= {master_s[1:0], master_pin};
            hold_acknowledge_s <= {hold_acknowledge_s[1:0], hold_acknowledge_b};
            wait_s <= {wait_s[1:0], wait_b};
        end
    end

    wire idle_done = (idle_cnt == EBS_IDLE_COUNT - 9'h001);
    wire read_done = (wait_cnt == EBS_READ_WAIT_COUNT);
    wire in_read = (state == EBS_READ);
    wire emu_region = (lmb_addr[31:24] == EBS_EMU_SEG_TOP);
    // width flag picks 32 or 16
    wire width32 = cfg_word[EBS_WIDTH_BIT];
    wire [15:0] cfg_low = cfg_word[15:0];
    wire [1:0] next_port_width = width32 ? EBS_PORTW_32 : EBS_PORTW_16;
    // wait sampled only outside the config read
    wire wait_eff = in_read ? 1'b0 : ~wait_s[2];

    always_comb begin
        next_state = state;
        case (state)
            EBS_RESET: begin
                if (strap_taken) begin
                    if (emu_mode) begin
                        // no config read on emulation boot
                        next_state = EBS_RUN;
                    end else if (boot_mode) begin
                        next_state = EBS_IDLE;
                    end else begin
                        next_state = EBS_OFF;
                    end
                end
            end
            EBS_IDLE: next_state = idle_done ? EBS_READ : EBS_IDLE;
            EBS_READ: next_state = read_done ? EBS_APPLY : EBS_READ;
            EBS_APPLY: next_state = EBS_RUN;
            EBS_RUN: next_state = EBS_RUN;
            EBS_OFF: next_state = EBS_OFF;
            default: next_state = EBS_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= EBS_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Straps caught once after release, never at reset itself
    // Wait until the sync chain has filled, else the reset zeros are taken
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
            strap_taken <= 1'b0;
            boot_mode <= 1'b0;
            emu_mode <= 1'b0;
            ext_master <= 1'b0;
        end else if (!strap_taken) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == 2'h3) begin
                strap_taken <= 1'b1;
                boot_mode <= ext_boot_s[2];
                emu_mode <= emu_boot_s[2];
                ext_master <= ext_boot_s[2] & master_s[2];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt <= 9'h000;
            wait_cnt <= 8'h00;
        end else begin
            idle_cnt <= (state == EBS_IDLE) ? idle_cnt + 9'h001 : 9'h000;
            wait_cnt <= in_read ? wait_cnt + 8'h01 : 8'h00;
        end
    end

    // single capture of the config word
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_word <= 32'h00000000;
        end else if (in_read && read_done) begin
            cfg_word <= rd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_addr <= EBS_FETCH_ADDR;
            rd_b <= 1'b1;
            boot_chip_select_b <= 1'b1;
            fetch_start <= 1'b0;
        end else begin
            ext_addr <= in_read ? EBS_CFG_ADDR : EBS_FETCH_ADDR;
            rd_b <= ~(in_read && !read_done);
            boot_chip_select_b <= ~(in_read && !read_done);
            // first fetch from zero after apply
            fetch_start <= (state == EBS_APPLY);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_width <= EBS_PORTW_16;
            chip_select_bus_control <= EBS_BUSCON_RESET;
            chip_select_access_parameters <= EBS_BUSAP_RESET;
        end else if (state == EBS_APPLY) begin
            port_width <= next_port_width;
            chip_select_bus_control <= {width32, 1'b0, cfg_low[11:10], cfg_low[9:8], cfg_low[7], 9'h000};
            chip_select_access_parameters <= {cfg_low[14:12], 6'h00, cfg_low[6:5], cfg_low[4:2], 2'h0};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            emulation_address_select <= EBS_EMU_AS_RESET;
            emulation_bus_control <= EBS_EMU_BC_RESET;
            emulation_access_parameters <= EBS_EMU_BAP_RESET;
        end else begin
            emulation_address_select <= EBS_EMU_AS_RESET;
            emulation_bus_control <= EBS_EMU_BC_RESET;
            emulation_access_parameters <= EBS_EMU_BAP_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_pc <= 32'h00000000;
            pc_load <= 1'b0;
            unit_enable <= 1'b0;
        end else begin
            pc_load <= (state == EBS_RESET) && strap_taken;
            if ((state == EBS_RESET) && strap_taken) begin
                cpu_pc <= emu_mode ? EBS_EMU_BASE : 32'h00000000;
            end
            unit_enable <= (next_state == EBS_RUN);
        end
    end

    // unit owns bus out of reset; arbitration on after an external boot strap, off otherwise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_owner <= 1'b1;
            arb_enable <= 1'b0;
        end else begin
            bus_owner <= (state != EBS_OFF) & hold_acknowledge_s[2];
            arb_enable <= boot_mode & strap_taken;
        end
    end

    // retry during config read; refuse when off, except in the emulation region
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lmb_retry <= 1'b0;
            lmb_error <= 1'b0;
            boot_done <= 1'b0;
        end else begin
            lmb_retry <= lmb_req & (state != EBS_RUN) & (state != EBS_OFF) & ~wait_eff;
            lmb_error <= lmb_req & (state == EBS_OFF) & ~emu_region;
            boot_done <= (state == EBS_RUN);
        end
    end

    assign cs.emu_hit = emu_region & lmb_req & (state == EBS_RUN);
    assign cs.cs_hit = cs_hit & {7{state == EBS_RUN}};
    assign cs.ovl_en = overlay_enable_control;

    ebs_overlay_dec u_dec (
        .cs(cs)
    );

    // inverted overlay select drives external gating
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_b <= 7'h7f;
            overlay_chip_select_b <= 1'b1;
            emulation_chip_select_b <= 1'b1;
        end else begin
            cs_b <= ~cs.cs_sel;
            overlay_chip_select_b <= ~cs.ovl_sel;
            emulation_chip_select_b <= ~cs.emu_sel;
        end
    end
endmodule

// [logic/ebs_overlay_dec.sv]
// Purpose: Per chip select overlay and emulation select generation
// Assumes: Hits come from the address compare of the current access
// Notes: Overlay uses the timing of the regular chip select it shadows
`timescale 1ns/1ps
module ebs_overlay_dec (
    ebs_cs_if.dec cs // Decode group
);
    wire [6:0] ovl_hit;
    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_ovl
            assign ovl_hit[i] = cs.cs_hit[i] & cs.ovl_en[i];
        end
    endgenerate
    assign cs.ovl_sel = |ovl_hit;
    assign cs.cs_sel = cs.cs_hit;
    assign cs.emu_sel = cs.emu_hit;
endmodule

// [verif/ebs_boot_monitor.sv]
// Purpose: Port assertions for the boot configuration loader
// Assumes: One clock domain, async active-low reset
// Notes: Boot-phase checks are gated by boot_done, since normal traffic reuses the strobes
`timescale 1ns/1ps
module ebs_boot_monitor
    import ebs_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic lmb_req, // Local request
    input wire logic [31:0] lmb_addr, // Local address
    input wire logic [31:0] rd_data, // Read data
    input wire logic [6:0] overlay_enable_control, // Overlay enables
    input wire logic [EBS_ADDR_W-1:0] ext_addr, // External address
    input wire logic rd_b, // Read strobe
    input wire logic boot_chip_select_b, // Select zero
    input wire logic [6:0] cs_b, // Regular selects
    input wire logic overlay_chip_select_b, // Overlay select
    input wire logic emulation_chip_select_b, // Emulation select
    input wire logic lmb_retry, // Retry answer
    input wire logic lmb_error, // Error answer
    input wire logic arb_enable, // Arbitration on
    input wire logic fetch_start, // First fetch
    input wire logic [1:0] port_width, // Width code
    input wire logic boot_done // Boot finished
);
    logic [8:0] low_cnt;
    logic [9:0] since_rst;
    logic [1:0] falls;
    logic wide;
    logic [7:0] addr_top;
    assign addr_top = lmb_addr[31:24];
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 9'h000;
            since_rst <= 10'h000;
            falls <= 2'h0;
            wide <= 1'b0;
        end else begin
            low_cnt <= rd_b ? 9'h000 : low_cnt + 9'h001;
            since_rst <= (since_rst == 10'h3ff) ? since_rst : since_rst + 10'h001;
            falls <= falls + 2'(($fell(rd_b) && !boot_done && falls != 2'h3));
            wide <= rd_b ? wide : rd_data[EBS_WIDTH_BIT];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_read_length: assert property ($rose(rd_b) && !$past(boot_done) |-> low_cnt == 9'd224)
        else $error("config read strobe length wrong");
    a_idle_gap: assert property ($fell(rd_b) && !boot_done |-> since_rst inside {[256:270]})
        else $error("config read started outside idle gap");
    a_cfg_addr: assert property (!rd_b && !boot_done |-> ext_addr == EBS_CFG_ADDR && !boot_chip_select_b)
        else $error("config read not at offset four on select zero");
    a_single_read: assert property (falls <= 2'h1)
        else $error("more than one config read");
    a_retry_busy: assert property (lmb_req && !rd_b && !boot_done |=> lmb_retry)
        else $error("local request not retried during config read");
    a_width_code: assert property (fetch_start && falls == 2'h1 |-> port_width == (wide ? EBS_PORTW_32 : EBS_PORTW_16))
        else $error("port width code does not follow width flag");
    a_fetch_zero: assert property (fetch_start && falls == 2'h1 |-> ext_addr == EBS_FETCH_ADDR && rd_b)
        else $error("first fetch not at location zero");
    a_refuse_off: assert property (lmb_error |-> !arb_enable && $past(lmb_req))
        else $error("error answer without request or with arbitration on");
    a_overlay_pair: assert property (!overlay_chip_select_b |-> (~cs_b & $past(overlay_enable_control)) != 7'h00)
        else $error("overlay select without enabled regular select");
    a_emu_window: assert property (!emulation_chip_select_b |-> $past(addr_top) == EBS_EMU_SEG_TOP)
        else $error("emulation select outside its window");
    c_fetch: cover property (fetch_start);
    c_retry: cover property (lmb_retry);
    c_overlay: cover property (!overlay_chip_select_b);
endmodule
bind ebs_boot_ctrl ebs_boot_monitor mon_u (.ref_clk, .rst_b, .lmb_req, .lmb_addr, .rd_data, .overlay_enable_control,
    .ext_addr, .rd_b, .boot_chip_select_b, .cs_b, .overlay_chip_select_b, .emulation_chip_select_b, .lmb_retry,
    .lmb_error, .arb_enable, .fetch_start, .port_width, .boot_done);

// [verif/ebs_boot_rom.sv]
// Purpose: Behavioural boot ROM on select zero
// Assumes: Demultiplexed bus, combinational read
// Notes: Undriven data lines churn so a stale value never looks valid
`timescale 1ns/1ps
module ebs_boot_rom
    import ebs_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic boot_chip_select_b, // Select zero
    input wire logic rd_b, // Read strobe
    input wire logic [EBS_ADDR_W-1:0] ext_addr, // Address
    input wire logic [31:0] cfg_word, // Word held at offset four
    output logic [31:0] rd_data // Data lines
);
    logic [31:0] churn = 32'h00000000;
    always_ff @(posedge ref_clk) churn <= ~churn ^ 32'h5a5a0f0f;
    // ROM answers reads on select zero only
    assign rd_data = (!boot_chip_select_b && !rd_b) ? ((ext_addr == EBS_CFG_ADDR) ? cfg_word : 32'h0000a5c3) : churn;
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the boot loader
// Assumes: 100 MHz clock, inputs driven 1 ns after the edge
// Notes: Config read length is checked exactly by the monitor, its start against a 256 to 270 cycle window
`timescale 1ns/1ps
module tb_top;
    import ebs_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, ext_boot = 1'b0, emu_boot = 1'b0, master_pin = 1'b0, wait_b = 1'b1;
    logic hold_acknowledge_b = 1'b1, lmb_req = 1'b0;
    logic [31:0] lmb_addr = 32'h00000000, cfg_word = 32'h00000000, rd_data, cpu_pc;
    logic [6:0] overlay_enable_control = 7'h00, cs_hit = 7'h00, cs_b;
    logic [EBS_ADDR_W-1:0] ext_addr;
    logic rd_b, boot_chip_select_b, overlay_chip_select_b, emulation_chip_select_b, lmb_retry, lmb_error;
    logic bus_owner, ext_master, arb_enable, unit_enable, pc_load, fetch_start, boot_done;
    logic [1:0] port_width;
    logic [15:0] chip_select_bus_control, chip_select_access_parameters;
    logic [15:0] emulation_address_select, emulation_bus_control, emulation_access_parameters;
    int num_errors = 0, check_count = 0, cycles = 0, falls = 0;
    always #5 ref_clk = ~ref_clk;
    ebs_boot_ctrl dut_u (.ref_clk, .rst_b, .ext_boot, .emu_boot, .master_pin, .wait_b, .hold_acknowledge_b, .rd_data,
        .lmb_req, .lmb_addr, .overlay_enable_control, .cs_hit, .ext_addr, .rd_b, .boot_chip_select_b, .cs_b,
        .overlay_chip_select_b, .emulation_chip_select_b, .lmb_retry, .lmb_error, .bus_owner, .ext_master, .arb_enable,
        .unit_enable, .cpu_pc, .pc_load, .fetch_start, .port_width, .chip_select_bus_control,
        .chip_select_access_parameters, .emulation_address_select, .emulation_bus_control,
        .emulation_access_parameters, .boot_done);
    ebs_boot_rom rom_u (.ref_clk, .boot_chip_select_b, .rd_b, .ext_addr, .cfg_word, .rd_data);
    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            conclude;
        end
    end
    always @(negedge rd_b) if (rst_b === 1'b1) falls++;
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // Hold acknowledge stays high as its pull-up would keep it
    task automatic restart(input logic eb, input logic emb, input logic mp);
        rst_b = 1'b0;
        ext_boot = eb;
        emu_boot = emb;
        master_pin = mp;
        lmb_req = 1'b0;
        tick(10);
        rst_b = 1'b1;
        falls = 0;
    endtask
    task automatic test_ext_boot(input logic [31:0] cfg, input logic mp, input logic [1:0] exp_w);
        int took;
        int gap;
        took = 0;
        gap = 0;
        cfg_word = cfg;
        restart(1'b1, 1'b0, mp);
        check(bus_owner === 1'b1, "bus not owned after reset");
        while (rd_b !== 1'b0 && gap < 400) begin tick(1); gap++; end
        check(gap >= EBS_IDLE_CYCLES, "config read started early");
        check(ext_addr === EBS_CFG_ADDR && boot_chip_select_b === 1'b0, "config read address");
        // Wait pin held asserted through the read; it must not stretch it
        wait_b = 1'b0;
        lmb_addr = 32'h00000100;
        lmb_req = 1'b1;
        tick(1);
        check(lmb_retry === 1'b1, "no retry during config read");
        lmb_req = 1'b0;
        while (fetch_start !== 1'b1 && took < 400) begin tick(1); took++; end
        wait_b = 1'b1;
        check(took >= 215 && took <= 235, "config read length");
        check(port_width === exp_w, "port width code");
        check(ext_addr === EBS_FETCH_ADDR && falls == 1, "first fetch after one read");
        check(ext_master === mp, "master pin not taken");
        $display("test ext boot done, cfg %h", cfg);
    endtask
    task automatic test_overlay;
        logic [6:0] en [3] = '{7'h05, 7'h05, 7'h7f};
        logic [6:0] hit [3] = '{7'h04, 7'h02, 7'h40};
        logic [2:0] exp_b = 3'b010;
        for (int i = 0; i < 3; i++) begin
            overlay_enable_control = en[i];
            cs_hit = hit[i];
            lmb_addr = 32'h00100000;
            lmb_req = 1'b1;
            tick(2);
            check(cs_b === ~hit[i], "regular select");
            check(overlay_chip_select_b === exp_b[i], "overlay select");
            lmb_req = 1'b0;
            tick(2);
        end
        $display("test overlay done");
    endtask
    task automatic test_emu_boot;
        int took;
        took = 0;
        restart(1'b0, 1'b1, 1'b1);
        while (pc_load !== 1'b1 && took < 50) begin tick(1); took++; end
        check(cpu_pc === EBS_EMU_BASE && unit_enable === 1'b1, "emulation start");
        check(emulation_address_select === EBS_EMU_AS_RESET, "emulation region preset");
        check(emulation_bus_control === EBS_EMU_BC_RESET, "emulation control preset");
        check(emulation_access_parameters === EBS_EMU_BAP_RESET, "emulation timing preset");
        lmb_addr = 32'hde000010;
        lmb_req = 1'b1;
        tick(3);
        check(emulation_chip_select_b === 1'b0, "emulation select inside window");
        lmb_addr = 32'hdf000000;
        tick(3);
        check(emulation_chip_select_b === 1'b1, "emulation select outside window");
        lmb_req = 1'b0;
        tick(300);
        check(falls == 0, "config read during emulation boot");
        $display("test emu boot done");
    endtask
    task automatic test_no_boot;
        restart(1'b0, 1'b0, 1'b0);
        tick(20);
        check(arb_enable === 1'b0, "arbitration on without boot");
        lmb_addr = 32'h00001000;
        lmb_req = 1'b1;
        tick(1);
        check(lmb_error === 1'b1, "external access not refused");
        lmb_req = 1'b0;
        tick(2);
        $display("test no boot done");
    endtask
    initial begin
        test_ext_boot(32'hffff7fff, 1'b1, EBS_PORTW_16);
        test_overlay;
        test_ext_boot(32'h00008000, 1'b0, EBS_PORTW_32);
        test_emu_boot;
        test_no_boot;
        conclude;
    end
endmodule
